// >>> include/pcw_pkg.sv
// constants and types of the pipe configuration window
package pcw_pkg;

	// ========================================
	// register map
	localparam logic [7:0] PCW_CHOOSER_OFS = 8'h8C;
	localparam logic [7:0] PCW_WINDOW_OFS = 8'h90;
	localparam logic [15:0] PCW_WINDOW_RST = 16'h0000;
	localparam logic [2:0] PCW_CHOOSER_RST = 3'h0;
	localparam logic [2:0] PCW_CHOOSER_NONE = 3'h0;
	localparam logic [2:0] PCW_PIPE_LAST = 3'h6;
	localparam int PCW_NPIPE = 6;

	// ========================================
	// window field positions
	localparam int PCW_B_ENABLE = 15;
	localparam int PCW_B_TOGGLE = 13;
	localparam int PCW_B_BUFRDY = 10;
	localparam int PCW_B_DOUBLE = 9;
	localparam int PCW_B_CONT = 8;
	localparam int PCW_B_DIR = 4;

	// ========================================
	// transfer sizes in bytes and counter reset values
	localparam logic [10:0] PCW_FS_MPS = 11'h040;
	localparam logic [10:0] PCW_HS_MPS = 11'h200;
	localparam logic [10:0] PCW_CONT_LIMIT = 11'h200;
	localparam logic [10:0] PCW_ACC_RST = 11'h000;
	localparam logic [15:0] PCW_PKT_RST = 16'h0000;

	// ========================================
	// types
	typedef struct packed {
		logic pipe_enable;
		logic irq_xfer_toggle_mode;
		logic buf_ready_irq_mode;
		logic double_buffering;
		logic continuous_xfer_mode;
		logic dir_in;
	} pcw_cfg_t;

	typedef enum logic [1:0] {PCW_EV_TX, PCW_EV_WR, PCW_EV_RX, PCW_EV_BUFFER_VALID_FLAG} pcw_evk_t;

	typedef struct packed {
		logic valid;
		logic [2:0] pipe;
		pcw_evk_t kind;
		logic [10:0] bytes;
		logic acked;
	} pcw_ev_t;

	typedef struct packed {
		logic [5:0] tx_done;
		logic [5:0] wr_done;
		logic [5:0] rx_done;
		logic [5:0] pid_toggle;
		logic [5:0] resend;
		logic [5:0] buffer_valid_flag_clear;
		logic [5:0] bufrdy_set;
	} pcw_stat_t;

endpackage

// >>> design/pcw_top.sv
// pipe configuration window with avalon slave and completion tracking
//
// Operation
// - selector value picks pipe one to six
// - bit 15 enables the selected pipe
// - toggle bit works only on pipes five, six
// - toggle off: advance always; without ACK clear valid, flag
// - toggle on: advance on ACK, else resend
// - bit 10 buffer-ready mode, pipes one-four
// - bit 9 double buffering, pipes one, two
// - continuous bit pipes one-four, ignored at HS
// - FS single IN completes at 64 bytes
// - FS single OUT completes at 64 or short
// - FS continuous IN completes at 512 bytes
// - FS continuous OUT: 512, short, or count
// - HS IN completes at 512 or short
// - HS OUT completes at 512 or short
// - bit 4 direction pipes one-four only
// - low bits read endpoint number, read-only
// - resets clear all; bus reset clears 15
// - reserved bits read zero
`timescale 1ns/1ps
module pcw_top import pcw_pkg::*; (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sw_reset,
	input wire logic usb_bus_reset,
	input wire logic usb_hi_speed,
	input wire logic [15:0] transaction_counter,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire pcw_ev_t xfer_ev,
	output pcw_cfg_t [5:0] pipe_cfg,
	output pcw_stat_t pipe_stat
);

	// ========================================
	// bus slave
	logic wait_q;
	logic [31:0] rdata_q;
	logic [2:0] chooser_q;
	pcw_cfg_t [5:0] cfg_q;
	pcw_stat_t stat_q;

	wire logic req = avs_read | avs_write;
	wire logic wait_d = ~(req & wait_q);
	wire logic wr_commit = avs_write & ~wait_q;
	wire logic rd_take = avs_read & wait_q;
	wire logic hit_chooser = avs_address == PCW_CHOOSER_OFS;
	wire logic hit_window = avs_address == PCW_WINDOW_OFS;
	wire logic win_commit = wr_commit & hit_window;
	wire logic sel_valid = (chooser_q != PCW_CHOOSER_NONE) && (chooser_q <= PCW_PIPE_LAST);
	wire logic [2:0] sel_idx = chooser_q - 3'h1;
	wire pcw_cfg_t sel_cfg = cfg_q[sel_idx];
	wire logic [15:0] win_rd = sel_valid ? {sel_cfg.pipe_enable, 1'h0,
		sel_cfg.irq_xfer_toggle_mode, 2'h0, sel_cfg.buf_ready_irq_mode,
		sel_cfg.double_buffering, sel_cfg.continuous_xfer_mode, 3'h0,
		sel_cfg.dir_in, 1'h0, chooser_q} : 16'h0000;
	wire logic [31:0] rd_mux = hit_window ? {16'h0000, win_rd} :
		hit_chooser ? {29'h0, chooser_q} : 32'h0000_0000;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wait_q <= 1'h1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= wait_d;
			if (rd_take) begin
				rdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || sw_reset) begin
			chooser_q <= PCW_CHOOSER_RST;
		end else if (wr_commit && hit_chooser && avs_byteenable[0]) begin
			chooser_q <= avs_writedata[2:0];
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

	// ========================================
	// per pipe configuration and completion
	logic [5:0] tx_done_d;
	logic [5:0] wr_done_d;
	logic [5:0] rx_done_d;
	logic [5:0] pid_toggle_d;
	logic [5:0] resend_d;
	logic [5:0] buffer_valid_flag_clear_d;
	logic [5:0] bufrdy_set_d;

	wire logic [10:0] mps = usb_hi_speed ? PCW_HS_MPS : PCW_FS_MPS;
	wire logic be0 = avs_byteenable[0];
	wire logic be1 = avs_byteenable[1];

	for (genvar i = 0; i < PCW_NPIPE; i++) begin : g_pipe
		localparam logic can_toggle = (i >= 4);
		localparam logic can_bufrdy = (i < 4);
		localparam logic can_double = (i < 2);
		localparam logic can_cont = (i < 4);
		localparam logic can_dir = (i < 4);
		logic [10:0] tx_acc_q;
		logic [10:0] wr_acc_q;
		logic [10:0] rx_acc_q;
		logic [15:0] pkt_q;
		pcw_cfg_t c_d;
		pcw_cfg_t c_q;

		wire pcw_cfg_t c = cfg_q[i];
		wire logic sel_wr = win_commit && sel_valid && (chooser_q == 3'(i + 1));
		wire logic cont_eff = c.continuous_xfer_mode & ~usb_hi_speed;
		wire logic [10:0] limit = usb_hi_speed ? PCW_HS_MPS :
			cont_eff ? PCW_CONT_LIMIT : PCW_FS_MPS;
		wire logic is_in = c.dir_in | ~can_dir;
		wire logic ev_hit = xfer_ev.valid && (xfer_ev.pipe == 3'(i + 1)) && c.pipe_enable;
		wire logic short_pkt = xfer_ev.bytes < mps;
		wire logic toggle_off = c.irq_xfer_toggle_mode;
		wire logic tx_hit = ev_hit && (xfer_ev.kind == PCW_EV_TX) && is_in;
		wire logic wr_hit = ev_hit && (xfer_ev.kind == PCW_EV_WR) && is_in;
		wire logic bv_hit = ev_hit && (xfer_ev.kind == PCW_EV_BUFFER_VALID_FLAG) && is_in;
		wire logic rx_hit = ev_hit && (xfer_ev.kind == PCW_EV_RX) && ~is_in;
		wire logic advance = xfer_ev.acked | toggle_off;
		wire logic tx_adv = tx_hit & advance;
		wire logic [11:0] tx_sum = {1'h0, tx_acc_q} + {1'h0, xfer_ev.bytes};
		wire logic [11:0] wr_sum = {1'h0, wr_acc_q} + {1'h0, xfer_ev.bytes};
		wire logic [11:0] rx_sum = {1'h0, rx_acc_q} + {1'h0, xfer_ev.bytes};
		wire logic [15:0] pkt_next = pkt_q + 16'h0001;
		wire logic tx_end = tx_adv && (short_pkt || tx_sum >= {1'h0, limit});
		wire logic wr_end = bv_hit || (wr_hit && wr_sum >= {1'h0, limit});
		wire logic rx_end = rx_hit && (short_pkt || rx_sum >= {1'h0, limit} ||
			(cont_eff && pkt_next == transaction_counter));
		wire logic clr = reset | sw_reset | usb_bus_reset;

		always_comb begin
			c_d = c;
			if (sel_wr && be1) begin
				c_d.pipe_enable = avs_writedata[PCW_B_ENABLE];
				c_d.irq_xfer_toggle_mode = can_toggle & avs_writedata[PCW_B_TOGGLE];
				c_d.buf_ready_irq_mode = can_bufrdy ? avs_writedata[PCW_B_BUFRDY] :
					c.buf_ready_irq_mode;
				c_d.double_buffering = can_double ? avs_writedata[PCW_B_DOUBLE] :
					c.double_buffering;
				c_d.continuous_xfer_mode = can_cont ? avs_writedata[PCW_B_CONT] :
					c.continuous_xfer_mode;
			end
			if (sel_wr && be0 && can_dir) begin
				c_d.dir_in = avs_writedata[PCW_B_DIR];
			end
			if (usb_bus_reset) begin
				c_d.pipe_enable = 1'h0;
			end
		end

		always_ff @(posedge core_clk) begin
			if (reset || sw_reset) begin
				c_q <= pcw_cfg_t'(PCW_WINDOW_RST[5:0]);
			end else begin
				c_q <= c_d;
			end
		end

		assign cfg_q[i] = c_q;

		always_ff @(posedge core_clk) begin
			if (clr) begin
				tx_acc_q <= PCW_ACC_RST;
				wr_acc_q <= PCW_ACC_RST;
				rx_acc_q <= PCW_ACC_RST;
				pkt_q <= PCW_PKT_RST;
			end else begin
				if (tx_adv) begin
					tx_acc_q <= tx_end ? PCW_ACC_RST : tx_sum[10:0];
				end
				if (wr_hit || bv_hit) begin
					wr_acc_q <= wr_end ? PCW_ACC_RST : wr_sum[10:0];
				end
				if (rx_hit) begin
					rx_acc_q <= rx_end ? PCW_ACC_RST : rx_sum[10:0];
					pkt_q <= rx_end ? PCW_PKT_RST : pkt_next;
				end
			end
		end

		assign tx_done_d[i] = tx_end;
		assign wr_done_d[i] = wr_end;
		assign rx_done_d[i] = rx_end;
		assign pid_toggle_d[i] = tx_adv;
		assign resend_d[i] = tx_hit & ~advance;
		assign buffer_valid_flag_clear_d[i] = tx_hit & toggle_off & ~xfer_ev.acked;
		assign bufrdy_set_d[i] = tx_hit & toggle_off & ~xfer_ev.acked;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			stat_q <= '0;
		end else begin
			stat_q <= '{tx_done: tx_done_d, wr_done: wr_done_d, rx_done: rx_done_d,
				pid_toggle: pid_toggle_d, resend: resend_d,
				buffer_valid_flag_clear: buffer_valid_flag_clear_d, bufrdy_set: bufrdy_set_d};
		end
	end

	assign pipe_cfg = cfg_q;
	assign pipe_stat = stat_q;

	// ========================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	wire logic plain_win_wr = win_commit && !usb_bus_reset && !sw_reset;
	wire logic ev_p5_tx = xfer_ev.valid && xfer_ev.pipe == 3'h5 &&
		xfer_ev.kind == PCW_EV_TX && cfg_q[4].pipe_enable && !xfer_ev.acked;

	property p_wait_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");

	property p_req_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_req_answer: assert property (p_req_answer) else $error("request not answered");

	property p_none_ignored;
		plain_win_wr && chooser_q == PCW_CHOOSER_NONE |=> $stable(pipe_cfg);
	endproperty
	a_none_ignored: assert property (p_none_ignored) else $error("write with no pipe");

	property p_enable_wr;
		plain_win_wr && chooser_q == 3'h1 && avs_byteenable[1]
			|=> pipe_cfg[0].pipe_enable == $past(avs_writedata[15]);
	endproperty
	a_enable_wr: assert property (p_enable_wr) else $error("enable not written");

	property p_toggle_bulk;
		pipe_cfg[0].irq_xfer_toggle_mode == 1'h0 && pipe_cfg[3].irq_xfer_toggle_mode == 1'h0;
	endproperty
	a_toggle_bulk: assert property (p_toggle_bulk) else $error("bulk toggle bit set");

	property p_single_buf;
		pipe_cfg[2].double_buffering == 1'h0 && pipe_cfg[5].double_buffering == 1'h0;
	endproperty
	a_single_buf: assert property (p_single_buf) else $error("double buffer on single pipe");

	property p_ep_read;
		!avs_waitrequest && avs_read && hit_window && sel_valid
			|-> avs_readdata[2:0] == chooser_q;
	endproperty
	a_ep_read: assert property (p_ep_read) else $error("endpoint number wrong");

	property p_reserved_zero;
		!avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0000 &&
			avs_readdata[14] == 1'h0 && avs_readdata[12:11] == 2'h0 &&
			avs_readdata[7:5] == 3'h0 && avs_readdata[3] == 1'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_bus_reset;
		usb_bus_reset |=> pipe_cfg[0].pipe_enable == 1'h0 && pipe_cfg[5].pipe_enable == 1'h0 &&
			pipe_cfg[1].dir_in == $past(pipe_cfg[1].dir_in);
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("bus reset effect wrong");

	property p_resend;
		ev_p5_tx && !cfg_q[4].irq_xfer_toggle_mode
			|=> pipe_stat.resend[4] && !pipe_stat.pid_toggle[4];
	endproperty
	a_resend: assert property (p_resend) else $error("no resend without ack");

	property p_no_ack_adv;
		ev_p5_tx && cfg_q[4].irq_xfer_toggle_mode
			|=> pipe_stat.pid_toggle[4] && pipe_stat.buffer_valid_flag_clear[4] && pipe_stat.bufrdy_set[4];
	endproperty
	a_no_ack_adv: assert property (p_no_ack_adv) else $error("toggle-off advance missing");

	c_write_win: cover property (win_commit && sel_valid);
	c_tx_done: cover property (pipe_stat.tx_done[0]);
	c_rx_done: cover property (pipe_stat.rx_done[1]);
	c_resend: cover property (pipe_stat.resend[5]);

endmodule

// >>> sim/pcw_host_model.sv
// far-side stand-in: transfer engine and host handshake feeding events
`timescale 1ns/1ps
module pcw_host_model import pcw_pkg::*; (
	input wire logic core_clk,
	input wire logic reset,
	input wire pcw_ev_t ev_req,
	output pcw_ev_t xfer_ev
);
	// ========================================
	// one-cycle events; idle fields keep changing
	always_ff @(posedge core_clk) begin
		if (reset) begin
			xfer_ev <= 18'h0AAAA;
		end else if (ev_req.valid) begin
			xfer_ev <= ev_req;
		end else begin
			xfer_ev <= {1'b0, ~xfer_ev[16:0]};
		end
	end
endmodule

// >>> sim/tb.sv
// self-checking bench of the pipe configuration window
`timescale 1ns/1ps
module tb import pcw_pkg::*; ;
	logic core_clk = 0, reset = 1, sw_reset = 0, usb_bus_reset = 0, usb_hi_speed = 0;
	logic [15:0] transaction_counter = 16'h0000;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 0, avs_write = 0;
	logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
	logic [3:0] avs_byteenable = 4'h3;
	logic avs_waitrequest;
	pcw_ev_t ev_req = '0, xfer_ev;
	pcw_cfg_t [5:0] pipe_cfg;
	pcw_stat_t pipe_stat;
	int error_cnt = 0, n_checks = 0;
	localparam logic [7:0] CH = PCW_CHOOSER_OFS;
	localparam logic [7:0] WN = PCW_WINDOW_OFS;

	pcw_top u_dut (.core_clk(core_clk), .reset(reset), .sw_reset(sw_reset),
		.usb_bus_reset(usb_bus_reset), .usb_hi_speed(usb_hi_speed),
		.transaction_counter(transaction_counter), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .xfer_ev(xfer_ev), .pipe_cfg(pipe_cfg),
		.pipe_stat(pipe_stat));
	pcw_host_model u_host (.core_clk(core_clk), .reset(reset), .ev_req(ev_req),
		.xfer_ev(xfer_ev));

	always #2 core_clk = ~core_clk;

	// ========================================
	// bus master, events, compare
	task bus(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[15:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task chk(input logic [41:0] g, input logic [41:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd_chk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] q;
		bus(1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask
	function automatic logic [41:0] mk(int p, logic [6:0] m);
		logic [41:0] r = '0;
		for (int k = 0; k < 7; k++)
			for (int i = 0; i < 6; i++)
				if (m[k] && (p == 0 || i == p - 1)) r[k * 6 + i] = 1'b1;
		return r;
	endfunction
	task ev_chk(input int p, input pcw_evk_t k, input logic [10:0] b, input logic a,
		input logic [6:0] care, input logic [6:0] m);
		@(posedge core_clk);
		ev_req <= '{1'b1, 3'(p), k, b, a};
		@(posedge core_clk);
		ev_req.valid <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk(pipe_stat & mk(0, care), mk(p, m));
	endtask

	// ========================================
	// scenarios
	task t_reset;
		rd_chk(CH, 16'h0000);
		rd_chk(WN, 16'h0000);
		rd_chk(8'h40, 16'h0000);
		wr(WN, 16'hFFFF);
		wr(CH, 16'h0001);
		rd_chk(WN, 16'h0001);
		chk(pipe_cfg, 36'h0);
	endtask
	task t_fields;
		logic [15:0] e;
		for (int p = 1; p <= 6; p++) begin
			e = 16'h8000 | 16'(p);
			e |= (p >= 5) ? 16'h2000 : 16'h0510;
			if (p <= 2) e |= 16'h0200;
			wr(CH, 16'(p));
			wr(WN, 16'hFFFF);
			rd_chk(WN, e);
			chk(pipe_cfg[p - 1], {1'b1, e[13], e[10], e[9], e[8], e[4]});
		end
		wr(CH, 16'h0007);
		rd_chk(WN, 16'h0000);
	endtask
	task t_toggle;
		ev_chk(5, PCW_EV_TX, 11'h008, 1'b0, 7'h4F, 7'h4B);
		wr(CH, 16'h0005);
		wr(WN, 16'h8000);
		ev_chk(5, PCW_EV_TX, 11'h008, 1'b0, 7'h4F, 7'h04);
		ev_chk(5, PCW_EV_TX, 11'h008, 1'b1, 7'h0C, 7'h08);
	endtask
	task t_in;
		wr(CH, 16'h0001);
		wr(WN, 16'h8010);
		ev_chk(1, PCW_EV_WR, 11'h020, 1'b0, 7'h20, 7'h00);
		ev_chk(1, PCW_EV_WR, 11'h020, 1'b0, 7'h20, 7'h20);
		ev_chk(1, PCW_EV_BUFFER_VALID_FLAG, 11'h000, 1'b0, 7'h20, 7'h20);
		ev_chk(1, PCW_EV_TX, 11'h040, 1'b1, 7'h40, 7'h40);
		wr(WN, 16'h8110);
		repeat (7) ev_chk(1, PCW_EV_TX, 11'h040, 1'b1, 7'h40, 7'h00);
		ev_chk(1, PCW_EV_TX, 11'h040, 1'b1, 7'h40, 7'h40);
		@(posedge core_clk) usb_hi_speed <= 1'b1;
		ev_chk(1, PCW_EV_WR, 11'h100, 1'b0, 7'h20, 7'h00);
		ev_chk(1, PCW_EV_WR, 11'h100, 1'b0, 7'h20, 7'h20);
		ev_chk(1, PCW_EV_TX, 11'h200, 1'b1, 7'h40, 7'h40);
		@(posedge core_clk) usb_hi_speed <= 1'b0;
	endtask
	task t_out;
		wr(CH, 16'h0002);
		wr(WN, 16'h8000);
		ev_chk(2, PCW_EV_TX, 11'h008, 1'b1, 7'h7F, 7'h00);
		ev_chk(2, PCW_EV_RX, 11'h040, 1'b0, 7'h10, 7'h10);
		ev_chk(2, PCW_EV_RX, 11'h010, 1'b0, 7'h10, 7'h10);
		wr(WN, 16'h8100);
		@(posedge core_clk) transaction_counter <= 16'h0003;
		repeat (2) ev_chk(2, PCW_EV_RX, 11'h040, 1'b0, 7'h10, 7'h00);
		ev_chk(2, PCW_EV_RX, 11'h040, 1'b0, 7'h10, 7'h10);
		@(posedge core_clk) usb_hi_speed <= 1'b1;
		ev_chk(2, PCW_EV_RX, 11'h200, 1'b0, 7'h10, 7'h10);
		ev_chk(2, PCW_EV_RX, 11'h100, 1'b0, 7'h10, 7'h10);
		ev_chk(2, PCW_EV_RX, 11'h064, 1'b0, 7'h10, 7'h10);
		@(posedge core_clk) usb_hi_speed <= 1'b0;
	endtask
	task t_resets;
		@(posedge core_clk) usb_bus_reset <= 1'b1;
		@(posedge core_clk) usb_bus_reset <= 1'b0;
		wr(CH, 16'h0001);
		rd_chk(WN, 16'h0111);
		ev_chk(1, PCW_EV_TX, 11'h008, 1'b1, 7'h7F, 7'h00);
		@(posedge core_clk) sw_reset <= 1'b1;
		@(posedge core_clk) sw_reset <= 1'b0;
		rd_chk(CH, 16'h0000);
		wr(CH, 16'h0001);
		rd_chk(WN, 16'h0001);
	endtask

	// ========================================
	// run control
	task print_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_fields();
		t_toggle();
		t_in();
		t_out();
		t_resets();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		print_verdict();
	end
endmodule
